// ==== adc_serial_command_decoder.sv ====
// Command decoder of a sigma-delta converter readout device
`timescale 1ns/1ps
//
// Contract
// [RL1] Commands decode from the upper nibble; don't-care bits are ignored.
// [RL2] Register read (0100) returns the register addressed by the low nibble.
// [RL3] Register write (0101) takes address nibble, then a data byte to store.
// [RL4] Read once (0001) shifts out the 24-bit result, three bytes, MSB first.
// [RL5] Host reads exactly three bytes after a read once command.
// [RL6] Result waiting goes high once the three-byte read completes.
// [RL7] Continuous mode (0010) offers each new result for a three-byte read.
// [RL8] In continuous mode, each three-byte read drives result waiting high.
// [RL9] Host sends stop continuous before any other command.
// [RL10] Stop continuous (0011) leaves the mode; result waiting goes high.
// [RL11] Internal offset cal (0110) shorts the input, stores 24-bit offset.
// [RL12] System offset calibration (0111) stores offset measured on channel.
// [RL13] Host applies zero input before system offset calibration.
// [RL14] Internal gain calibration (1000) stores the full-scale coefficient.
// [RL15] System gain calibration (1001) stores gain from channel input.
// [RL16] Host applies positive full-scale input before system gain cal.
// [RL17] Every calibration takes five conversions before storing its result.
// [RL18] Calibration completion drives result waiting low.
// [RL19] Coefficients only stored; correction applies only with enable bits.
// [RL20] Offset and full-scale registers readable and writable by commands.
// [RL21] Host restores gain by writing computed quotient after power-up.
// [RL22] New result drives result waiting low; it stays low until read.
// [RL23] Control write restarts modulator and filter; result waiting high.
// [RL24] Deselect resets serial state and releases the serial output.
// [RL25] Input sampled on rising, output launched on falling serial clock; the code drives each byte's MSB straight from tx_word.
// [RL26] Unknown opcodes are ignored and change no state.
// [RL27] After register read, next byte shifts the register out MSB first.
module adc_serial_command_decoder
  import adc_cmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  input  wire logic [23:0] conv_result,
  input  wire logic        conv_valid,
  input  wire logic [23:0] cal_offset_meas,
  input  wire logic [23:0] cal_gain_meas,
  output logic             result_waiting_n,
  output logic [7:0]       control_one,
  output logic [7:0]       control_two,
  output logic             filter_restart,
  output logic             offset_correct_on,
  output logic             gain_correct_on,
  output logic [23:0]      offset_applied,
  output logic [23:0]      gain_applied,
  output logic             cal_active,
  output logic             cal_short_input,
  output logic             cal_system,
  output logic             cal_gain
);
  import adc_cmd_pkg::*;

  // Register read mux
  function automatic logic [7:0] reg_rd(
    input logic [3:0]  a,
    input logic [23:0] res,
    input logic [7:0]  c1,
    input logic [7:0]  c2,
    input logic [23:0] ofs,
    input logic [23:0] fs
  );
    logic [7:0] v;
    v = BYTE_RST;
    unique case (a)
      ADDR_CODE_HI:       v = res[23:16];
      ADDR_CODE_MID:      v = res[15:8];
      ADDR_CODE_LO:       v = res[7:0];
      ADDR_CTRL_ONE:      v = c1;
      ADDR_CTRL_TWO:      v = c2;
      ADDR_OFS_LO:        v = ofs[7:0];
      ADDR_OFS_LO + 4'h1: v = ofs[15:8];
      ADDR_OFS_LO + 4'h2: v = ofs[23:16];
      ADDR_FS_LO:         v = fs[7:0];
      ADDR_FS_LO + 4'h1:  v = fs[15:8];
      ADDR_FS_LO + 4'h2:  v = fs[23:16];
      default:            v = BYTE_RST;
    endcase
    return v;
  endfunction : reg_rd

  // Result byte by index, most significant first
  function automatic logic [7:0] res_byte(
    input logic [23:0] res,
    input logic [1:0]  idx
  );
    logic [7:0] v;
    v = res[23:16];
    if (idx == 2'h1) begin
      v = res[15:8];
    end else if (idx == 2'h2) begin
      v = res[7:0];
    end
    return v;
  endfunction : res_byte

  cmd_state_t           state_q;
  cmd_state_t           state_d;
  cal_kind_t            cal_kind_q;
  cal_kind_t            cal_kind_d;
  logic [1:0]           byte_cnt_q;
  logic [1:0]           byte_cnt_d;
  logic [2:0]           cal_cnt_q;
  logic [3:0]           wr_addr_q;
  logic [7:0]           tx_word_q;
  logic [7:0]           tx_word_d;
  logic [23:0]          result_q;
  logic [7:0]           ctrl_one_q;
  logic [7:0]           ctrl_two_q;
  logic [23:0]          ofs_q;
  logic [23:0]          fs_q;
  logic                 waiting_n_q;
  logic                 restart_q;
  logic [23:0]          ofs_app_q;
  logic [23:0]          gain_app_q;
  logic [SYNC_DEPTH-1:0] rx_sync_q;
  logic                 rx_seen_q;
  logic [SYNC_DEPTH-1:0] ss_sync_q;
  logic [7:0]           rx_byte;
  logic                 rx_toggle;

  serial_link_shifter u_link (
    .sclk      (sclk),
    .arst_n    (arst_n),
    .ss_n      (ss_n),
    .din       (din),
    .tx_word   (tx_word_q),
    .dout      (dout),
    .dout_oe   (dout_oe),
    .rx_byte   (rx_byte),
    .rx_toggle (rx_toggle)
  );

  // Byte toggle and select crossing into the system clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync_q <= '0;
      rx_seen_q <= 1'b0;
      ss_sync_q <= '1;
    end else begin
      rx_sync_q <= {rx_sync_q[SYNC_DEPTH-2:0], rx_toggle};
      ss_sync_q <= {ss_sync_q[SYNC_DEPTH-2:0], ss_n};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_seen_q <= rx_sync_q[2];
      end
    end
  end

  wire       rx_stable = (rx_sync_q[1] == rx_sync_q[2]);
  wire       byte_evt  = rx_stable && (rx_sync_q[2] != rx_seen_q);
  wire       deselect  = ss_sync_q[1] & ss_sync_q[2];
  wire [3:0] opc       = rx_byte[OPC_MSB:OPC_LSB]; // [RL1]
  wire [3:0] adr       = rx_byte[ADDR_MSB:ADDR_LSB];

  wire in_idle  = (state_q == ST_IDLE);
  wire in_once  = (state_q == ST_ONCE);
  wire in_cont  = (state_q == ST_CONT);
  wire cal_busy = (cal_kind_q != CAL_NONE);
  wire mid_read = (in_once || (in_cont && byte_cnt_q != 2'h0));
  wire idle_evt = byte_evt && in_idle && !deselect;
  wire cont_evt = byte_evt && in_cont && !deselect;

  wire take_write = byte_evt && !deselect && (state_q == ST_WR_DATA);
  wire wr_ctrl    = take_write &&
                    (wr_addr_q == ADDR_CTRL_ONE ||
                     wr_addr_q == ADDR_CTRL_TWO); // [RL23]
  wire stop_cont  = cont_evt && (opc == OP_STOP_CONT) &&
                    (byte_cnt_q == 2'h0); // [RL10]
  wire stop_idle  = idle_evt && (opc == OP_STOP_CONT);
  wire last_byte  = (byte_cnt_q == LAST_RES_BYTE);
  wire read_done  = byte_evt && !deselect && last_byte &&
                    (in_once || (in_cont && !stop_cont)); // [RL6] [RL8]
  wire is_cal_op  = (opc == OP_INT_OFS_CAL) || (opc == OP_SYS_OFS_CAL) ||
                    (opc == OP_INT_GN_CAL)  || (opc == OP_SYS_GN_CAL);
  wire cal_start  = idle_evt && is_cal_op && !cal_busy;
  wire cal_done   = cal_busy && conv_valid &&
                    (cal_cnt_q == LAST_CAL_CONV); // [RL17]
  wire cal_to_ofs = (cal_kind_q == CAL_INT_OFS) ||
                    (cal_kind_q == CAL_SYS_OFS);
  wire new_result = conv_valid && !cal_busy && !mid_read;

  // Command sequencing
  always_comb begin
    state_d    = state_q;
    byte_cnt_d = byte_cnt_q;
    tx_word_d  = tx_word_q;
    cal_kind_d = cal_kind_q;
    if (cal_done) begin
      cal_kind_d = CAL_NONE;
    end
    if (deselect) begin
      state_d    = ST_IDLE; // [RL24]
      byte_cnt_d = 2'h0;
    end else if (byte_evt) begin
      unique case (state_q)
        ST_IDLE: begin
          unique case (opc) // [RL1]
            OP_READ_ONCE: begin
              state_d    = ST_ONCE; // [RL4]
              byte_cnt_d = 2'h0;
              tx_word_d  = res_byte(result_q, 2'h0);
            end
            OP_READ_CONT: begin
              state_d    = ST_CONT; // [RL7]
              byte_cnt_d = 2'h0;
              tx_word_d  = res_byte(result_q, 2'h0);
            end
            OP_REG_READ: begin
              state_d   = ST_REG_OUT;
              tx_word_d = reg_rd(adr, result_q, ctrl_one_q, ctrl_two_q,
                                 ofs_q, fs_q); // [RL2] [RL20] [RL27]
            end
            OP_REG_WRITE: begin
              state_d = ST_WR_DATA; // [RL3]
            end
            OP_INT_OFS_CAL: begin
              if (!cal_busy) cal_kind_d = CAL_INT_OFS; // [RL11]
            end
            OP_SYS_OFS_CAL: begin
              if (!cal_busy) cal_kind_d = CAL_SYS_OFS; // [RL12]
            end
            OP_INT_GN_CAL: begin
              if (!cal_busy) cal_kind_d = CAL_INT_GN; // [RL14]
            end
            OP_SYS_GN_CAL: begin
              if (!cal_busy) cal_kind_d = CAL_SYS_GN; // [RL15]
            end
            default: begin
              state_d = ST_IDLE; // [RL26]
            end
          endcase
        end
        ST_WR_DATA: begin
          state_d = ST_IDLE;
        end
        ST_REG_OUT: begin
          state_d = ST_IDLE;
        end
        ST_ONCE: begin
          if (last_byte) begin
            state_d    = ST_IDLE;
            byte_cnt_d = 2'h0;
          end else begin
            byte_cnt_d = byte_cnt_q + 2'h1;
            tx_word_d  = res_byte(result_q, byte_cnt_q + 2'h1); // [RL4]
          end
        end
        ST_CONT: begin
          if (stop_cont) begin
            state_d = ST_IDLE;
          end else if (last_byte) begin
            byte_cnt_d = 2'h0;
            tx_word_d  = res_byte(result_q, 2'h0);
          end else begin
            byte_cnt_d = byte_cnt_q + 2'h1;
            tx_word_d  = res_byte(result_q, byte_cnt_q + 2'h1); // [RL7]
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (new_result && in_cont && !byte_evt) begin
      tx_word_d = res_byte(conv_result, 2'h0); // [RL7]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      byte_cnt_q <= 2'h0;
      tx_word_q  <= BYTE_RST;
      cal_kind_q <= CAL_NONE;
    end else begin
      state_q    <= state_d;
      byte_cnt_q <= byte_cnt_d;
      tx_word_q  <= tx_word_d;
      cal_kind_q <= cal_kind_d;
    end
  end

  // Write address and calibration conversion count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_addr_q <= 4'h0;
      cal_cnt_q <= 3'h0;
    end else begin
      if (idle_evt && opc == OP_REG_WRITE) begin
        wr_addr_q <= adr; // [RL3]
      end
      if (cal_start) begin
        cal_cnt_q <= 3'h0;
      end else if (cal_busy && conv_valid) begin
        cal_cnt_q <= cal_cnt_q + 3'h1; // [RL17]
      end
    end
  end

  // Result latch; held during a read once and from the second byte of a continuous read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= RESULT_RST;
    end else if (new_result) begin
      result_q <= conv_result;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_one_q <= CTRL_RST;
      ctrl_two_q <= CTRL_RST;
    end else if (take_write) begin
      if (wr_addr_q == ADDR_CTRL_ONE) ctrl_one_q <= rx_byte; // [RL3]
      if (wr_addr_q == ADDR_CTRL_TWO) ctrl_two_q <= rx_byte;
    end
  end

  // Coefficient byte lanes; calibration result wins over a write
  genvar g;
  generate
    for (g = 0; g < COEF_BYTES; g++) begin : g_lane
      localparam logic [3:0] OFS_A = ADDR_OFS_LO + 4'(g);
      localparam logic [3:0] FS_A  = ADDR_FS_LO + 4'(g);
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ofs_q[8*g +: 8] <= COEF_RST[8*g +: 8];
          fs_q[8*g +: 8]  <= COEF_RST[8*g +: 8];
        end else begin
          if (cal_done && cal_to_ofs) begin
            ofs_q[8*g +: 8] <= cal_offset_meas[8*g +: 8]; // [RL11] [RL12]
          end else if (take_write && wr_addr_q == OFS_A) begin
            ofs_q[8*g +: 8] <= rx_byte; // [RL20]
          end
          if (cal_done && !cal_to_ofs) begin
            fs_q[8*g +: 8] <= cal_gain_meas[8*g +: 8]; // [RL14] [RL15]
          end else if (take_write && wr_addr_q == FS_A) begin
            fs_q[8*g +: 8] <= rx_byte; // [RL20]
          end
        end
      end
    end
  endgenerate

  // Result waiting: a new result or finished calibration beats any clear
  wire wait_low  = new_result || cal_done; // [RL18] [RL22]
  wire wait_high = read_done || stop_cont || stop_idle || wr_ctrl;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waiting_n_q <= 1'b1;
    end else if (wait_low) begin
      waiting_n_q <= 1'b0; // [RL22]
    end else if (wait_high) begin
      waiting_n_q <= 1'b1; // [RL6] [RL8] [RL10] [RL23]
    end
  end

  // Correction terms and restart strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restart_q  <= 1'b0;
      ofs_app_q  <= COEF_RST;
      gain_app_q <= COEF_RST;
    end else begin
      restart_q  <= wr_ctrl; // [RL23]
      ofs_app_q  <= ctrl_one_q[OFS_ON_BIT] ? ofs_q : COEF_RST; // [RL19]
      gain_app_q <= ctrl_one_q[GAIN_ON_BIT] ? fs_q : COEF_RST; // [RL19]
    end
  end

  assign result_waiting_n  = waiting_n_q;
  assign control_one       = ctrl_one_q;
  assign control_two       = ctrl_two_q;
  assign filter_restart    = restart_q;
  assign offset_correct_on = ctrl_one_q[OFS_ON_BIT];
  assign gain_correct_on   = ctrl_one_q[GAIN_ON_BIT];
  assign offset_applied    = ofs_app_q;
  assign gain_applied      = gain_app_q;
  assign cal_active        = cal_busy;
  assign cal_short_input   = (cal_kind_q == CAL_INT_OFS); // [RL11]
  assign cal_system        = (cal_kind_q == CAL_SYS_OFS) ||
                             (cal_kind_q == CAL_SYS_GN);
  assign cal_gain          = (cal_kind_q == CAL_INT_GN) ||
                             (cal_kind_q == CAL_SYS_GN);

endmodule : adc_serial_command_decoder

// ==== adc_cmd_pkg.sv ====
// Shared constants and types for the serial command decoder
package adc_cmd_pkg;

  // Opcodes held in the upper nibble of a command byte
  localparam logic [3:0] OP_READ_ONCE   = 4'h1;
  localparam logic [3:0] OP_READ_CONT   = 4'h2;
  localparam logic [3:0] OP_STOP_CONT   = 4'h3;
  localparam logic [3:0] OP_REG_READ    = 4'h4;
  localparam logic [3:0] OP_REG_WRITE   = 4'h5;
  localparam logic [3:0] OP_INT_OFS_CAL = 4'h6;
  localparam logic [3:0] OP_SYS_OFS_CAL = 4'h7;
  localparam logic [3:0] OP_INT_GN_CAL  = 4'h8;
  localparam logic [3:0] OP_SYS_GN_CAL  = 4'h9;

  // Command byte fields
  localparam int OPC_MSB  = 7;
  localparam int OPC_LSB  = 4;
  localparam int ADDR_MSB = 3;
  localparam int ADDR_LSB = 0;

  // Register addresses
  localparam logic [3:0] ADDR_CODE_HI  = 4'h0;
  localparam logic [3:0] ADDR_CODE_MID = 4'h1;
  localparam logic [3:0] ADDR_CODE_LO  = 4'h2;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h3;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h4;
  localparam logic [3:0] ADDR_OFS_LO   = 4'h8;
  localparam logic [3:0] ADDR_FS_LO    = 4'hB;

  // Field positions in control_one
  localparam int OFS_ON_BIT  = 4;
  localparam int GAIN_ON_BIT = 3;

  // Reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [23:0] COEF_RST   = 24'h00_0000;
  localparam logic [23:0] RESULT_RST = 24'h00_0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;

  // Counts
  localparam int         COEF_BYTES     = 3;
  localparam logic [1:0] LAST_RES_BYTE  = 2'h2;
  localparam logic [2:0] LAST_CAL_CONV  = 3'h4;
  localparam int         SYNC_DEPTH     = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR_DATA,
    ST_REG_OUT,
    ST_ONCE,
    ST_CONT
  } cmd_state_t;

  typedef enum logic [2:0] {
    CAL_NONE,
    CAL_INT_OFS,
    CAL_SYS_OFS,
    CAL_INT_GN,
    CAL_SYS_GN
  } cal_kind_t;

endpackage : adc_cmd_pkg

// ==== serial_link_shifter.sv ====
// Serial link shifter running on the host's serial clock
`timescale 1ns/1ps
module serial_link_shifter
  import adc_cmd_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       arst_n,
  input  wire logic       ss_n,
  input  wire logic       din,
  input  wire logic [7:0] tx_word,
  output logic            dout,
  output logic            dout_oe,
  output logic [7:0]      rx_byte,
  output logic            rx_toggle
);
  import adc_cmd_pkg::*;

  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  logic [7:0] tx_cap_q;
  logic       dout_q;
  logic [7:0] rx_byte_q;
  logic       rx_toggle_q;

  wire        link_rst_n = arst_n & ~ss_n;
  wire        byte_end   = (bit_cnt_q == 3'h7);
  wire [2:0]  out_idx    = 3'h7 - bit_cnt_q;

  // Deselect clears the partial byte and releases the output [RL24]
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q   <= 7'h00;
      tx_cap_q  <= BYTE_RST;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q   <= {rx_sh_q[5:0], din}; // [RL25]
      if (bit_cnt_q == 3'h0) begin
        tx_cap_q <= tx_word;
      end
    end
  end

  // Byte hand-off survives deselect so the toggle stays consistent
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_byte_q   <= BYTE_RST;
      rx_toggle_q <= 1'b0;
    end else if (!ss_n && byte_end) begin
      rx_byte_q   <= {rx_sh_q, din}; // [RL25]
      rx_toggle_q <= ~rx_toggle_q;
    end
  end

  // Output bits after each byte's MSB launched on the falling edge [RL25]
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= tx_cap_q[out_idx];
    end
  end

  assign dout      = (bit_cnt_q == 3'h0) ? tx_word[7] : dout_q; // [RL27]
  assign dout_oe   = ~ss_n; // [RL24]
  assign rx_byte   = rx_byte_q;
  assign rx_toggle = rx_toggle_q;

endmodule : serial_link_shifter

// ==== adc_cmd_monitor.sv ====
// Assertion checker for the serial command decoder
`timescale 1ns/1ps
module adc_cmd_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ss_n,
  input wire logic        dout_oe,
  input wire logic        conv_valid,
  input wire logic        result_waiting_n,
  input wire logic        filter_restart,
  input wire logic        offset_correct_on,
  input wire logic        gain_correct_on,
  input wire logic [23:0] offset_applied,
  input wire logic [23:0] gain_applied,
  input wire logic        cal_active,
  input wire logic        cal_short_input,
  input wire logic        cal_system,
  input wire logic        cal_gain
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // Conversions seen during the running calibration
  assign cnt_d = !cal_active ? 3'h0 : cnt_q + {2'h0, conv_valid};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 3'h0;
    else cnt_q <= cnt_d;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_quiet; ss_n [*6]; endsequence
  sequence s_idle; ss_n [*8]; endsequence
  sequence s_fifth; cal_active && conv_valid && cnt_q == 3'h4; endsequence

  property p_oe; dout_oe == !ss_n; endproperty
  property p_ofs_off;
    !offset_correct_on && !$past(offset_correct_on) |->
      offset_applied == 24'h00_0000;
  endproperty
  property p_gn_off;
    !gain_correct_on && !$past(gain_correct_on) |->
      gain_applied == 24'h00_0000;
  endproperty
  property p_new;
    s_quiet ##0 (conv_valid && !cal_active) |=> !result_waiting_n;
  endproperty
  property p_hold; s_idle ##0 !result_waiting_n |=> !result_waiting_n; endproperty
  property p_cal_done; s_fifth |=> !cal_active && !result_waiting_n; endproperty
  property p_cal_hold;
    cal_active && !(conv_valid && cnt_q == 3'h4) |=> cal_active;
  endproperty
  property p_kind;
    cal_short_input |-> cal_active && !cal_system && !cal_gain;
  endproperty
  property p_restart;
    filter_restart && !$past(conv_valid) |-> result_waiting_n;
  endproperty

  a_oe: assert property (p_oe)
    else $error("output enable not following select");
  a_ofs_off: assert property (p_ofs_off)
    else $error("offset applied while disabled");
  a_gn_off: assert property (p_gn_off)
    else $error("gain applied while disabled");
  a_new: assert property (p_new)
    else $error("new result not flagged");
  a_hold: assert property (p_hold)
    else $error("result flag rose without a read");
  a_cal_done: assert property (p_cal_done)
    else $error("calibration not finished on fifth conversion");
  a_cal_hold: assert property (p_cal_hold)
    else $error("calibration ended early");
  a_kind: assert property (p_kind)
    else $error("calibration kind flags inconsistent");
  a_restart: assert property (p_restart)
    else $error("control write left result flag low");
endmodule : adc_cmd_monitor

bind adc_serial_command_decoder adc_cmd_monitor u_mon (.clk, .arst_n, .ss_n,
  .dout_oe, .conv_valid, .result_waiting_n, .filter_restart,
  .offset_correct_on, .gain_correct_on, .offset_applied, .gain_applied,
  .cal_active, .cal_short_input, .cal_system, .cal_gain);

// ==== host_link_model.sv ====
// Host-side serial link master model
`timescale 1ns/1ps
module host_link_model (
  output logic      sclk,
  output logic      ss_n,
  output logic      din,
  input  wire logic dout
);
  localparam realtime HALF = 7.5;
  localparam realtime GAP  = 60.0;

  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    din  = 1'b0;
  end

  task automatic sel();
    ss_n = 1'b0;
    #GAP;
  endtask : sel

  // Data line goes meaningless once deselected
  task automatic desel();
    ss_n = 1'b1;
    din  = ~din;
    #GAP;
  endtask : desel

  // One byte MSB first; clock stands still in the gap after it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #HALF sclk = 1'b1;
      rx[i] = dout;
      #HALF sclk = 1'b0;
    end
    #GAP;
  endtask : xfer
endmodule : host_link_model

// ==== tb_adc_serial_command_decoder.sv ====
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
module tb_adc_serial_command_decoder;
  import adc_cmd_pkg::*;
  logic        clk, arst_n, sclk, ss_n, din, dout, dout_oe, conv_valid;
  logic        result_waiting_n, filter_restart, offset_correct_on;
  logic        gain_correct_on, cal_active, cal_short_input, cal_system;
  logic        cal_gain;
  logic [23:0] conv_result, cal_offset_meas, cal_gain_meas, v;
  logic [23:0] offset_applied, gain_applied;
  logic [7:0]  control_one, control_two, rx;
  int          errors, comparisons, cycles, restarts;

  adc_serial_command_decoder u_dut (.clk, .arst_n, .sclk, .ss_n, .din,
    .dout, .dout_oe, .conv_result, .conv_valid, .cal_offset_meas,
    .cal_gain_meas, .result_waiting_n, .control_one, .control_two,
    .filter_restart, .offset_correct_on, .gain_correct_on, .offset_applied,
    .gain_applied, .cal_active, .cal_short_input, .cal_system, .cal_gain);
  host_link_model u_host (.sclk, .ss_n, .din, .dout);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (filter_restart === 1'b1) restarts++;
    if (cycles == 30000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wclk

  task automatic conv(input logic [23:0] res);
    @(posedge clk);
    conv_result <= res;
    conv_valid  <= 1'b1;
    @(posedge clk);
    conv_valid  <= 1'b0;
    wclk(2);
  endtask : conv

  task automatic cmd(input logic [7:0] c);
    u_host.sel();
    u_host.xfer(c, rx);
    u_host.desel();
  endtask : cmd

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    u_host.sel();
    u_host.xfer({OP_REG_WRITE, a}, rx);
    u_host.xfer(d, rx);
    u_host.desel();
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    u_host.sel();
    u_host.xfer({OP_REG_READ, a}, rx);
    u_host.xfer(8'h00, rx);
    u_host.desel();
    check("reg read", {16'h0000, rx}, {16'h0000, exp});
  endtask : rd_reg

  task automatic rd3();
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(8'h00, rx);
      v = {v[15:0], rx};
    end
  endtask : rd3

  initial begin
    arst_n = 1'b0;
    conv_valid = 1'b0;
    conv_result = 24'h00_0000;
    cal_offset_meas = 24'h00_0000;
    cal_gain_meas = 24'h00_0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    wclk(6);
    check("oe idle", {23'h0, dout_oe}, 24'h0);
    for (int i = 0; i < 6; i++)
      wr_reg(4'(ADDR_OFS_LO + i), 8'(8'h11 * (i + 1)));
    wr_reg(ADDR_CTRL_ONE, 8'h18);
    check("ctrl one", {16'h0, control_one}, 24'h18);
    check("restarts", 24'(restarts), 24'h1);
    check("ofs applied", offset_applied, 24'h33_2211);
    check("gain applied", gain_applied, 24'h66_5544);
    wr_reg(ADDR_CTRL_TWO, 8'h2C);
    check("ctrl two", {16'h0, control_two}, 24'h2C);
    check("ofs on", {23'h0, offset_correct_on}, 24'h1);
    check("restarts", 24'(restarts), 24'h2);
    for (int i = 0; i < 6; i++)
      rd_reg(4'(ADDR_OFS_LO + i), 8'(8'h11 * (i + 1)));
    rd_reg(4'h5, 8'h00);
    wr_reg(4'hA, 8'h33);
    u_host.sel();
    u_host.xfer(8'hA3, rx);
    u_host.xfer(8'hFF, rx);
    u_host.desel();
    check("ctrl unknown", {16'h0, control_one}, 24'h18);
    wr_reg(ADDR_CTRL_ONE, 8'h08);
    check("ofs off", offset_applied, 24'h00_0000);
    conv(24'h12_3456);
    wclk(20);
    check("flag new", {23'h0, result_waiting_n}, 24'h0);
    u_host.sel();
    u_host.xfer(8'h17, rx);
    rd3();
    check("flag once", {23'h0, result_waiting_n}, 24'h1);
    u_host.desel();
    check("once data", v, 24'h12_3456);
    u_host.sel();
    u_host.xfer(8'h2F, rx);
    conv(24'hAB_CDEF);
    rd3();
    check("cont data", v, 24'hAB_CDEF);
    check("flag cont", {23'h0, result_waiting_n}, 24'h1);
    conv(24'h13_579B);
    rd3();
    check("cont data", v, 24'h13_579B);
    conv(24'h24_68AC);
    check("flag cont", {23'h0, result_waiting_n}, 24'h0);
    u_host.xfer(8'h3C, rx);
    check("flag stop", {23'h0, result_waiting_n}, 24'h1);
    u_host.desel();
    rd_reg(ADDR_CTRL_ONE, 8'h08);
    wr_reg(ADDR_CTRL_ONE, 8'h18);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cal_offset_meas <= 24'hFF_FF00 - 24'(k);
      cal_gain_meas <= 24'h41_22B7 + 24'(k);
      cmd(8'(8'h6A + 8'h10 * k));
      check("cal short", {23'h0, cal_short_input}, 24'(k == 0));
      check("cal sys", {23'h0, cal_system}, 24'(k % 2));
      check("cal gain", {23'h0, cal_gain}, 24'(k > 1));
      repeat (4) conv(24'h77_7777);
      check("cal run", {23'h0, cal_active}, 24'h1);
      conv(24'h77_7777);
      check("cal end", {23'h0, cal_active}, 24'h0);
      check("flag cal", {23'h0, result_waiting_n}, 24'h0);
      if (k < 2)
        check("ofs cal", offset_applied, 24'hFF_FF00 - 24'(k));
      else check("fs cal", gain_applied, 24'h41_22B7 + 24'(k));
    end
    rd_reg(4'hD, 8'h41);
    check("ctrl after cal", {16'h0, control_one}, 24'h18);
    cmd(8'h30);
    check("flag stop idle", {23'h0, result_waiting_n}, 24'h1);
    conv(24'h5A_5A5A);
    check("flag new", {23'h0, result_waiting_n}, 24'h0);
    wr_reg(ADDR_CTRL_TWO, 8'h2D);
    check("flag ctrl wr", {23'h0, result_waiting_n}, 24'h1);
    v = 24'(40'hFF_FFC0_0000 / 40'h3E_E259);
    for (int i = 0; i < 3; i++)
      wr_reg(4'(ADDR_FS_LO + i), v[8*i +: 8]);
    check("fs restored", gain_applied, v);
    test_done();
  end
endmodule : tb_adc_serial_command_decoder
